// File: hdl/trigger_timebase_generator.sv
// trigger and timebase: reference dividers, slow clock, trigger and gate
// assumes the reference and trigger pins are asynchronous to clk_sys and
// that the reference is slow enough to be sampled by it
//
// Behaviour
// - Divide the 60 MHz reference by four to 15 MHz.
// - Divide 15 MHz by ten to the 1.5 MHz common clock.
// - Reset all low dividers together; they share the common clock.
// - Common clock divided by six gives the 250 kHz reference.
// - Common clock divided by eight gives the 187.5 kHz square wave.
// - Common clock divided by fifteen gives a narrow 100 kHz pulse.
// - Host writes a ratio; common clock divided by it is slow clock.
// - Programmable timer sets delay and width of gated-sweep window.
// - Outputs sweep sync, gated-sweep sync and capture gate enable.
// - One source: internal, bus or external; internal needs no arming.
// - Bus and external sources ignored unless host enables them.
// - Trigger latched, emitted as sweep sync after next slow rise.
// - First sweep-sync fall after rearm or power-up resets filter phase.
// - Later sweep-sync falls are the instrument's sweep signal.
// - In gated mode each gated-sync rise alone is the sweep signal.
// - Host exchanges all configuration through the register port.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module trigger_timebase_generator
  import tbg_pkg::*;
#(
  parameter int RATIO_W = 16
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 ref_in,
  input  wire logic                 ext_trig_in,
  input  wire logic                 bus_trigger_in,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  logic [31:0]          reg_rdata,
  output var  tbg_pkg::ref_out_t    ref_out,
  output var  logic                 sweep_sync_n,
  output var  logic                 gated_sweep_sync,
  output var  logic                 capture_gate_en,
  output var  logic                 filt_phase_rst,
  output var  logic                 sweep_strobe
);
  import tbg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] in_s1_q, in_s2_q, in_s3_q;
  logic       ref_edge;
  logic [1:0] trg_edge;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_s1_q <= 3'h0;
      in_s2_q <= 3'h0;
      in_s3_q <= 3'h0;
    end else begin
      in_s1_q <= {bus_trigger_in, ext_trig_in, ref_in};
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
    end
  end

  assign ref_edge = in_s2_q[0] & ~in_s3_q[0];
  assign trg_edge = in_s2_q[2:1] & ~in_s3_q[2:1];

  ////////////////////////////////////////////////////////////////////////
  // registers
  ctrl_t              ctrl_q, ctrl_d;
  logic [RATIO_W-1:0] ratio_q, ratio_d, delay_q, delay_d, width_q, width_d;
  logic [31:0]        rdata_d;
  logic               rearm, resync;
  logic [31:0]        status;

  function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
    return reg_wr && (reg_addr == a);
  endfunction : wr_hit

  assign rearm  = wr_hit(A_CTRL) & reg_wdata[B_REARM];
  assign resync = wr_hit(A_CTRL) & reg_wdata[B_RESYNC];

  always_comb begin
    ctrl_d  = ctrl_q;
    ratio_d = ratio_q;
    delay_d = delay_q;
    width_d = width_q;
    rdata_d = 32'h0;
    if (wr_hit(A_CTRL)) ctrl_d = reg_wdata[5:0];
    if (wr_hit(A_RATIO)) ratio_d = reg_wdata[RATIO_W-1:0];
    if (wr_hit(A_DELAY)) delay_d = reg_wdata[RATIO_W-1:0];
    if (wr_hit(A_WIDTH)) width_d = reg_wdata[RATIO_W-1:0];
    if (reg_rd) begin
      unique case (reg_addr)
        A_CTRL:   rdata_d = {26'h0, ctrl_q};
        A_RATIO:  rdata_d = {{(32-RATIO_W){1'b0}}, ratio_q};
        A_DELAY:  rdata_d = {{(32-RATIO_W){1'b0}}, delay_q};
        A_WIDTH:  rdata_d = {{(32-RATIO_W){1'b0}}, width_q};
        A_STATUS: rdata_d = status;
        default:  rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q    <= CTRL_RST;
      ratio_q   <= RATIO_RST[RATIO_W-1:0];
      delay_q   <= DELAY_RST[RATIO_W-1:0];
      width_q   <= WIDTH_RST[RATIO_W-1:0];
      reg_rdata <= 32'h0;
    end else begin
      ctrl_q    <= ctrl_d;
      ratio_q   <= ratio_d;
      delay_q   <= delay_d;
      width_q   <= width_d;
      reg_rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference dividers
  logic [1:0]         pre_q, pre_d;
  logic [3:0]         com_q, com_d, d15_q, d15_d, pw_q, pw_d;
  logic [2:0]         d6_q, d6_d, d8_q, d8_d;
  logic [RATIO_W-1:0] slow_q, slow_d, ratio_m1, half;
  logic               tick15, tick_c, slow_rise;
  ref_out_t           ref_d;

  assign tick15    = ref_edge && (pre_q == DIV_REF);
  assign tick_c    = tick15 && (com_q == DIV_COM);
  assign ratio_m1  = (ratio_q == '0) ? '0 : ratio_q - 1'b1;
  assign half      = ratio_q - (ratio_q >> 1);
  assign slow_rise = tick_c && (slow_q >= ratio_m1);

  always_comb begin
    pre_d  = pre_q;
    com_d  = com_q;
    d6_d   = d6_q;
    d8_d   = d8_q;
    d15_d  = d15_q;
    slow_d = slow_q;
    pw_d   = (pw_q != 4'h0) ? pw_q - 4'h1 : 4'h0;
    if (ref_edge) pre_d = tick15 ? 2'h0 : pre_q + 2'h1;
    if (tick15) com_d = tick_c ? 4'h0 : com_q + 4'h1;
    if (resync) begin
      d6_d   = 3'h0;
      d8_d   = 3'h0;
      d15_d  = 4'h0;
      slow_d = '0;
      pw_d   = 4'h0;
    end else if (tick_c) begin
      d6_d   = (d6_q == DIV_250) ? 3'h0 : d6_q + 3'h1;
      d8_d   = (d8_q == DIV_187) ? 3'h0 : d8_q + 3'h1;
      d15_d  = (d15_q == DIV_100) ? 4'h0 : d15_q + 4'h1;
      slow_d = slow_rise ? '0 : slow_q + 1'b1;
      if (d15_q == DIV_100) pw_d = PW_CYC[3:0];
    end
    ref_d.common = com_d < COM_HALF;
    ref_d.f250   = d6_d < HALF_250;
    ref_d.f187   = d8_d < HALF_187;
    ref_d.p100   = pw_d != 4'h0;
    ref_d.slow   = slow_d < half;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre_q   <= 2'h0;
      com_q   <= 4'h0;
      d6_q    <= 3'h0;
      d8_q    <= 3'h0;
      d15_q   <= 4'h0;
      pw_q    <= 4'h0;
      slow_q  <= '0;
      ref_out <= REF_RST;
    end else begin
      pre_q   <= pre_d;
      com_q   <= com_d;
      d6_q    <= d6_d;
      d8_q    <= d8_d;
      d15_q   <= d15_d;
      pw_q    <= pw_d;
      slow_q  <= slow_d;
      ref_out <= ref_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger select, latch and sweep sync
  logic pend_q, pend_d, first_q, first_d, trig_evt, emit, sweep_fall;
  logic sweep_n_d, filt_d, strobe_d;

  always_comb begin
    unique case (ctrl_q.src)
      SRC_INT: trig_evt = slow_rise;
      SRC_BUS: trig_evt = ctrl_q.bus_en & trg_edge[1];
      SRC_EXT: trig_evt = ctrl_q.ext_en & trg_edge[0];
      default: trig_evt = 1'b0;
    endcase
  end

  assign emit       = slow_rise & pend_q;
  assign sweep_fall = emit & sweep_sync_n;

  ////////////////////////////////////////////////////////////////////////
  // gated-sweep window timer
  gate_state_t        gst_q, gst_d;
  logic [RATIO_W-1:0] gcnt_q, gcnt_d;
  logic               open_d;

  always_comb begin
    gst_d  = gst_q;
    gcnt_d = gcnt_q;
    unique case (gst_q)
      G_IDLE: begin
        if (sweep_fall && ctrl_q.gate_mode) begin
          gst_d  = G_DELAY;
          gcnt_d = '0;
        end
      end
      G_DELAY: begin
        if (slow_rise) begin
          if (gcnt_q >= delay_q) begin
            gst_d  = G_OPEN;
            gcnt_d = '0;
          end else begin
            gcnt_d = gcnt_q + 1'b1;
          end
        end
      end
      G_OPEN: begin
        if (slow_rise) begin
          if (gcnt_q + 1'b1 >= width_q) gst_d = G_IDLE;
          gcnt_d = gcnt_q + 1'b1;
        end
      end
      default: gst_d = G_IDLE;
    endcase
    if (!ctrl_q.gate_mode) gst_d = G_IDLE;
    open_d = gst_d == G_OPEN;
  end

  always_comb begin
    pend_d    = trig_evt | (pend_q & ~emit);
    first_d   = rearm | (first_q & ~sweep_fall);
    sweep_n_d = emit ? 1'b0 : (tick_c ? 1'b1 : sweep_sync_n);
    filt_d    = sweep_fall & first_q;
    if (ctrl_q.gate_mode)
      strobe_d = open_d & ~gated_sweep_sync;
    else
      strobe_d = sweep_fall & ~first_q;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_q           <= 1'b0;
      first_q          <= 1'b1;
      sweep_sync_n     <= 1'b1;
      filt_phase_rst   <= 1'b0;
      sweep_strobe     <= 1'b0;
      gst_q            <= G_IDLE;
      gcnt_q           <= '0;
      gated_sweep_sync <= 1'b0;
      capture_gate_en  <= 1'b0;
    end else begin
      pend_q           <= pend_d;
      first_q          <= first_d;
      sweep_sync_n     <= sweep_n_d;
      filt_phase_rst   <= filt_d;
      sweep_strobe     <= strobe_d;
      gst_q            <= gst_d;
      gcnt_q           <= gcnt_d;
      gated_sweep_sync <= open_d;
      capture_gate_en  <= open_d & ctrl_q.cap_en;
    end
  end

  assign status = {26'h0, gst_q, first_q, pend_q, ref_out.slow,
                   sweep_sync_n};

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [1:0] h_ref_q;
  logic [3:0] h_t15_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      h_ref_q <= 2'h0;
      h_t15_q <= 4'h0;
    end else begin
      if (ref_edge) h_ref_q <= h_ref_q + 2'h1;
      if (tick15) h_t15_q <= tick_c ? 4'h0 : h_t15_q + 4'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_emit;
    slow_rise && pend_q;
  endsequence

  sequence s_low_edge;
    $fell(sweep_sync_n);
  endsequence

  chk_ref_div4: assert property (tick15 |-> h_ref_q == 2'h3)
    else $error("prescaler not dividing by four");
  chk_com_div10: assert property (tick_c |-> h_t15_q == 4'h9)
    else $error("common clock not every tenth 15 MHz tick");
  chk_f250_step: assert property (
    $changed(ref_out.f250) |-> $past(tick_c) || $past(resync))
    else $error("250 kHz output moved off a common tick");
  chk_f187_rise: assert property (
    $rose(ref_out.f187) |-> $past(d8_q) == DIV_187 || $past(resync))
    else $error("187.5 kHz rise not at divider wrap");
  chk_pulse_width: assert property (
    $rose(ref_out.p100) |=> ref_out.p100 [*3] ##1 !ref_out.p100)
    else $error("100 kHz pulse width wrong");
  chk_slow_rise: assert property (slow_rise |=> ref_out.slow)
    else $error("slow clock not high after wrap");
  chk_sync_emit: assert property (
    s_low_edge |-> $past(slow_rise && pend_q))
    else $error("sweep sync fell without slow rise");
  chk_pend_clear: assert property (
    s_emit ##0 !trig_evt |=> !pend_q)
    else $error("trigger not cleared after emission");
  chk_src_ignore: assert property (
    (ctrl_q.src == SRC_BUS && !ctrl_q.bus_en) ||
    (ctrl_q.src == SRC_EXT && !ctrl_q.ext_en) |-> !pend_d || pend_q)
    else $error("disabled source latched a trigger");
  chk_first_fall: assert property (
    s_low_edge ##0 $past(first_q) |-> filt_phase_rst && !sweep_strobe)
    else $error("first fall did not reset filter phase");
  chk_gate_open: assert property (
    $rose(gated_sweep_sync) |-> $past(gst_q) == G_DELAY)
    else $error("gate window opened without delay phase");
endmodule : trigger_timebase_generator
`default_nettype wire

// File: hdl/tbg_pkg.sv
// constants, register map and carrier types of the trigger/timebase block
// assumes a 40 MHz system clock and a plain strobe register port
package tbg_pkg;
  localparam int          CLK_NS     = 25;
  localparam int          PULSE_NS   = 100;
  localparam int          PW_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0]  DIV_REF    = 2'h3;   // 60 MHz / 4, terminal count
  localparam logic [3:0]  DIV_COM    = 4'h9;   // 15 MHz / 10
  localparam logic [2:0]  DIV_250    = 3'h5;   // 1.5 MHz / 6
  localparam logic [2:0]  DIV_187    = 3'h7;   // 1.5 MHz / 8
  localparam logic [3:0]  DIV_100    = 4'hE;   // 1.5 MHz / 15
  localparam logic [3:0]  COM_HALF   = 4'h5;
  localparam logic [2:0]  HALF_250   = 3'h3;
  localparam logic [2:0]  HALF_187   = 3'h4;
  localparam int          ADDR_W     = 3;
  localparam logic [2:0]  A_CTRL     = 3'h0;
  localparam logic [2:0]  A_RATIO    = 3'h1;
  localparam logic [2:0]  A_DELAY    = 3'h2;
  localparam logic [2:0]  A_WIDTH    = 3'h3;
  localparam logic [2:0]  A_STATUS   = 3'h4;
  localparam logic [15:0] RATIO_RST  = 16'h0001;
  localparam logic [15:0] DELAY_RST  = 16'h0000;
  localparam logic [15:0] WIDTH_RST  = 16'h0001;
  localparam int          B_REARM    = 6;
  localparam int          B_RESYNC   = 7;

  typedef enum logic [1:0] {
    SRC_INT = 2'h0,
    SRC_BUS = 2'h1,
    SRC_EXT = 2'h2
  } trig_src_t;

  typedef enum logic [1:0] {
    G_IDLE  = 2'b00,
    G_DELAY = 2'b01,
    G_OPEN  = 2'b11
  } gate_state_t;

  typedef struct packed {
    logic      cap_en;
    logic      gate_mode;
    logic      bus_en;
    logic      ext_en;
    trig_src_t src;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{cap_en: 1'b0, gate_mode: 1'b0,
                                 bus_en: 1'b0, ext_en: 1'b0, src: SRC_INT};

  typedef struct packed {
    logic common;
    logic f250;
    logic f187;
    logic p100;
    logic slow;
  } ref_out_t;

  // levels that the zeroed counters give, so no output jumps after reset
  localparam ref_out_t REF_RST = '{common: 1'b1, f250: 1'b1, f187: 1'b1,
                                   p100: 1'b0, slow: 1'b1};
endpackage : tbg_pkg

// File: tb/host_model.sv
// host model: software side of the plain register port
// assumes read data stand in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module host_model
  import tbg_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic [31:0]               reg_rdata,
  output var  logic [tbg_pkg::ADDR_W-1:0] reg_addr,
  output var  logic [31:0]               reg_wdata,
  output var  logic                      reg_wr,
  output var  logic                      reg_rd
);
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // ratio, enables and source all go through these two cycles
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

// File: tb/trigger_timebase_generator_tb_top.sv
// testbench: reference dividers, slow clock, trigger path, gated sweep
// assumes host_model on the register port; ref_in toggles at clk/4
`timescale 1ns/1ps
`default_nettype none
module trigger_timebase_generator_tb_top;
  import tbg_pkg::*;
  localparam int COM = 4 * (int'(DIV_REF) + 1) * (int'(DIV_COM) + 1);
  logic              clk_sys = 1'b0;
  logic              rst     = 1'b1;
  logic [1:0]        ref_ph  = 2'h0;
  logic              ext_trig_in = 1'b0;
  logic              bus_trigger_in = 1'b0;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic [31:0]       reg_rdata;
  logic              reg_wr;
  logic              reg_rd;
  ref_out_t          ref_out;
  logic [4:0]        ro;
  logic              sweep_sync_n;
  logic              gated_sweep_sync;
  logic              capture_gate_en;
  logic              filt_phase_rst;
  logic              sweep_strobe;
  int                fail_count = 0;
  int                checks_done = 0;
  int                nf, np, ns, ng, ngt, nc, nr, nlow;

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) ref_ph <= ref_ph + 2'h1;
  assign ro = ref_out;

  trigger_timebase_generator i_trigger_timebase_generator (
    .clk_sys(clk_sys), .rst(rst), .ref_in(ref_ph[1]),
    .ext_trig_in(ext_trig_in), .bus_trigger_in(bus_trigger_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_out(ref_out),
    .sweep_sync_n(sweep_sync_n), .gated_sweep_sync(gated_sweep_sync),
    .capture_gate_en(capture_gate_en), .filt_phase_rst(filt_phase_rst),
    .sweep_strobe(sweep_strobe));

  host_model i_host_model (
    .clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      fail_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic lvl(input int b, input logic l, output int n);
    n = 0;
    while (ro[b] !== l && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : lvl

  task automatic meas(input int b, output int per, output int hi);
    int n;
    int lo;
    lvl(b, 1'b0, n);
    lvl(b, 1'b1, n);
    lvl(b, 1'b0, hi);
    lvl(b, 1'b1, lo);
    per = hi + lo;
  endtask : meas

  // counts edges and pulses of the trigger outputs over n cycles
  task automatic watch(input int n);
    logic ls;
    logic lg;
    bit   done;
    nf = 0; np = 0; ns = 0; ng = 0; ngt = 0; nc = 0; nr = 0; nlow = 0;
    done = 0;
    ls = sweep_sync_n;
    lg = gated_sweep_sync;
    repeat (n) begin
      @(posedge clk_sys);
      if (sweep_sync_n === 1'b0) begin
        nlow++;
        if (ls === 1'b1) nf++;
      end
      if (filt_phase_rst === 1'b1) np++;
      if (sweep_strobe === 1'b1) ns++;
      if (capture_gate_en === 1'b1) nc++;
      if (gated_sweep_sync === 1'b1) begin
        ngt++;
        if (!done) ng++;
        if (lg === 1'b0) nr++;
      end else if (ng > 0) done = 1;
      ls = sweep_sync_n;
      lg = gated_sweep_sync;
    end
  endtask : watch

  task automatic fire(input logic e, input logic b, input int ef,
                      input int ep, input int es);
    ext_trig_in    <= e;
    bus_trigger_in <= b;
    repeat (4) @(posedge clk_sys);
    ext_trig_in    <= 1'b0;
    bus_trigger_in <= 1'b0;
    watch(1000);
    chk(nf == ef && np == ep && ns == es, "sweep event count wrong");
    chk(nlow == ef * COM, "sweep sync low time wrong");
  endtask : fire

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    logic [31:0] ex [4];
    ex = '{{26'h0, CTRL_RST}, {16'h0, RATIO_RST}, {16'h0, DELAY_RST},
           {16'h0, WIDTH_RST}};
    repeat (4) @(posedge clk_sys);
    chk(sweep_sync_n === 1'b1 && ref_out === REF_RST, "reset levels");
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      i_host_model.rd(ADDR_W'(i), d);
      chk(d === ex[i], "register reset value");
    end
    i_host_model.wr(3'h7, 32'hFFFFFFFF);
    i_host_model.rd(3'h7, d);
    chk(d === 32'h0, "unmapped index not zero");
    i_host_model.wr(A_DELAY, 32'h1234);
    i_host_model.rd(A_DELAY, d);
    chk(d[15:0] === 16'h1234, "delay readback");
    i_host_model.wr(A_DELAY, 32'h0);
  endtask : t_reset

  task automatic t_dividers;
    int ep [5];
    int eh [5];
    int per;
    int hi;
    ep = '{0, COM * (int'(DIV_100) + 1), COM * (int'(DIV_187) + 1),
           COM * (int'(DIV_250) + 1), COM};
    eh = '{0, PW_CYC, COM * int'(HALF_187), COM * int'(HALF_250),
           16 * int'(COM_HALF)};
    for (int b = 1; b < 5; b++) begin
      meas(b, per, hi);
      chk(per == ep[b] && hi == eh[b], "divider output shape");
    end
  endtask : t_dividers

  task automatic t_slow;
    int per;
    int hi;
    i_host_model.wr(A_RATIO, 32'h4);
    meas(0, per, hi);
    meas(0, per, hi);
    chk(per == 4 * COM && hi == 2 * COM, "slow clock ratio 4");
    i_host_model.wr(A_RATIO, 32'h2);
    i_host_model.wr(A_CTRL, 32'h80);
    @(posedge clk_sys);
    chk(ro[3:0] === 4'hD, "resync did not restart dividers");
  endtask : t_slow

  task automatic t_trigger;
    i_host_model.wr(A_CTRL, 32'h2);
    repeat (700) @(posedge clk_sys);
    fire(1'b1, 1'b0, 0, 0, 0);
    i_host_model.wr(A_CTRL, 32'h46);
    fire(1'b1, 1'b0, 1, 1, 0);
    fire(1'b1, 1'b0, 1, 0, 1);
    i_host_model.wr(A_CTRL, 32'h9);
    fire(1'b1, 1'b0, 0, 0, 0);
    fire(1'b0, 1'b1, 1, 0, 1);
    i_host_model.wr(A_CTRL, 32'h0);
    watch(1000);
    chk(nf >= 2 && nf <= 4 && ns == nf, "internal trigger rate");
  endtask : t_trigger

  task automatic t_gated;
    logic [31:0] d;
    i_host_model.wr(A_WIDTH, 32'h1);
    i_host_model.wr(A_CTRL, 32'h30);
    watch(1500);
    chk(ng == 2 * COM && nc == ngt, "gate window width or capture");
    chk(nr > 0 && ns == nr, "gated sweep strobe");
    i_host_model.wr(A_CTRL, 32'h10);
    // let the enable cleared by the write reach the output flop
    repeat (2) @(posedge clk_sys);
    watch(1500);
    chk(ngt > 0 && nc == 0, "capture gate without enable");
    // close the window while it is really open
    for (int i = 0; i < 1000 && gated_sweep_sync !== 1'b1; i++)
      @(posedge clk_sys);
    chk(gated_sweep_sync === 1'b1, "window never reopened");
    i_host_model.wr(A_CTRL, 32'h20);
    repeat (2) @(posedge clk_sys);
    chk(gated_sweep_sync === 1'b0, "window not closed");
    i_host_model.rd(A_STATUS, d);
    chk(d[31:4] === 28'h0, "status gate state not idle");
  endtask : t_gated

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset();
    t_dividers();
    t_slow();
    t_trigger();
    t_gated();
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    give_verdict();
  end
endmodule : trigger_timebase_generator_tb_top
`default_nettype wire
